// ===== verilog/extlc_pkg.sv
// shared constants and types of the external line controller
package extlc_pkg;

  // ==========================================================
  // geometry
  localparam int NUM_LINES = 20;
  localparam int NUM_PINS  = 18;
  localparam int NUM_INT   = 2;
  localparam int ADR_W     = 8;
  localparam int STAT_W    = 3;

  // ==========================================================
  // register offsets (byte addresses)
  localparam logic [ADR_W-1:0] OFS_IRQ_EN   = 8'h00;
  localparam logic [ADR_W-1:0] OFS_EVT_EN   = 8'h04;
  localparam logic [ADR_W-1:0] OFS_RISE_SEL = 8'h08;
  localparam logic [ADR_W-1:0] OFS_FALL_SEL = 8'h0C;
  localparam logic [ADR_W-1:0] OFS_SOFT_TRG = 8'h10;
  localparam logic [ADR_W-1:0] OFS_PENDING  = 8'h14;
  localparam logic [ADR_W-1:0] OFS_STATUS   = 8'h18;
  localparam logic [ADR_W-1:0] OFS_STAT_CLR = 8'h1C;
  localparam logic [ADR_W-1:0] OFS_STAT_EN  = 8'h20;

  // ==========================================================
  // reset values
  localparam logic [NUM_LINES-1:0] LINES_RST = 20'h00000;
  localparam logic [STAT_W-1:0]    STAT_RST  = 3'h0;
  localparam logic [31:0]          WORD_ZERO = 32'h00000000;

  // ==========================================================
  // status bit positions
  localparam int ST_PEND_SET = 0;
  localparam int ST_PEND_HIT = 1;
  localparam int ST_EVT_OUT  = 2;

  // ==========================================================
  // bus access as seen by the register file
  typedef struct packed {
    logic [ADR_W-1:0] adr;
    logic             wr;
    logic             rd;
    logic [31:0]      dat;
    logic [31:0]      mask;
  } extlc_access_t;

  // configuration fields
  typedef struct packed {
    logic [NUM_LINES-1:0] irq_en;
    logic [NUM_LINES-1:0] evt_en;
    logic [NUM_LINES-1:0] rise_sel;
    logic [NUM_LINES-1:0] fall_sel;
  } extlc_cfg_t;

endpackage : extlc_pkg

// ===== verilog/extlc_edge_det.sv
// per-line edge detector with rise and fall selection
`timescale 1ns/10ps
module extlc_edge_det
  import extlc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic [NUM_LINES-1:0] line_lvl,
  input  wire logic [NUM_LINES-1:0] rise_trigger_sel,
  input  wire logic [NUM_LINES-1:0] fall_trigger_sel,
  output logic      [NUM_LINES-1:0] edge_hit
);

  logic [NUM_LINES-1:0] prev_q;

  // ==========================================================
  // previous sample; lines start low so a line high out of reset reads as a rise
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      prev_q <= LINES_RST;
    end else begin
      prev_q <= line_lvl;
    end
  end

  // ==========================================================
  // edge qualification
  genvar i;
  generate
    for (i = 0; i < NUM_LINES; i++) begin : g_line
      logic rise;
      logic fall;
      assign rise        = line_lvl[i] & ~prev_q[i];
      assign fall        = ~line_lvl[i] & prev_q[i];
      assign edge_hit[i] = (rise & rise_trigger_sel[i])
                         | (fall & fall_trigger_sel[i]);
    end
  endgenerate

endmodule : extlc_edge_det

// ===== verilog/extlc_wb_slave.sv
// classic wishbone slave front end, one wait state per access
`timescale 1ns/10ps
module extlc_wb_slave
  import extlc_pkg::*;
(
  input  wire logic             clk,
  input  wire logic             sys_rst,
  input  wire logic             wb_cyc,
  input  wire logic             wb_stb,
  input  wire logic             wb_we,
  input  wire logic [ADR_W-1:0] wb_adr,
  input  wire logic [3:0]       wb_sel,
  input  wire logic [31:0]      wb_dat_w,
  output logic      [31:0]      wb_dat_r,
  output logic                  wb_ack,
  output extlc_access_t         acc,
  input  wire logic [31:0]      rdata
);

  logic        ack_q;
  logic [31:0] dat_r_q;
  logic        take;

  // a request is taken once; the ack cycle itself blocks a second take
  assign take = wb_cyc & wb_stb & ~ack_q;

  always_comb begin
    acc.adr  = {wb_adr[ADR_W-1:2], 2'b00};
    acc.wr   = take & wb_we;
    acc.rd   = take & ~wb_we;
    acc.dat  = wb_dat_w;
    acc.mask = {{8{wb_sel[3]}}, {8{wb_sel[2]}}, {8{wb_sel[1]}}, {8{wb_sel[0]}}};
  end

  // ==========================================================
  // ack and read data
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= take;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      dat_r_q <= WORD_ZERO;
    end else if (take) begin
      dat_r_q <= wb_we ? WORD_ZERO : rdata;
    end
  end

  assign wb_ack   = ack_q;
  assign wb_dat_r = dat_r_q;

endmodule : extlc_wb_slave

// ===== verilog/extlc_top.sv
// external line interrupt and event controller, top level
//
// The implementer's own choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
module extlc_top
  import extlc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  // wishbone register port
  input  wire logic                 wb_cyc,
  input  wire logic                 wb_stb,
  input  wire logic                 wb_we,
  input  wire logic [ADR_W-1:0]     wb_adr,
  input  wire logic [3:0]           wb_sel,
  input  wire logic [31:0]          wb_dat_w,
  output logic      [31:0]          wb_dat_r,
  output logic                      wb_ack,
  // line sources
  input  wire logic [NUM_PINS-1:0]  pin_lines,
  input  wire logic                 supply_monitor_line,
  input  wire logic                 timer_wake_line,
  // requests
  output logic      [NUM_LINES-1:0] line_irq_req,
  output logic      [NUM_LINES-1:0] line_event,
  output logic                      ctrl_irq
);

  // ==========================================================
  // declarations
  extlc_access_t        acc;
  extlc_cfg_t           cfg;
  // configuration flops, one process each
  logic [NUM_LINES-1:0] irq_en_q;
  logic [NUM_LINES-1:0] evt_en_q;
  logic [NUM_LINES-1:0] rise_sel_q;
  logic [NUM_LINES-1:0] fall_sel_q;
  logic [NUM_LINES-1:0] soft_trigger_q;
  logic [NUM_LINES-1:0] soft_trigger_d;
  logic [NUM_LINES-1:0] pending_q;
  logic [NUM_LINES-1:0] pending_d;
  logic [NUM_LINES-1:0] event_q;
  logic [STAT_W-1:0]    status_q;
  logic [STAT_W-1:0]    status_d;
  logic [STAT_W-1:0]    stat_en_q;
  logic [NUM_LINES-1:0] line_lvl;
  logic [NUM_LINES-1:0] edge_hit;
  logic [NUM_LINES-1:0] soft_set;
  logic [NUM_LINES-1:0] pend_set;
  logic [NUM_LINES-1:0] pend_clr;
  logic [NUM_LINES-1:0] evt_fire;
  logic [STAT_W-1:0]    stat_hit;
  logic [31:0]          rdata;
  logic                 wr_irq_en;
  logic                 wr_evt_en;
  logic                 wr_rise;
  logic                 wr_fall;
  logic                 wr_soft;
  logic                 wr_pend;
  logic                 wr_sclr;
  logic                 wr_sen;
  logic [NUM_LINES-1:0] wmask;
  logic [NUM_LINES-1:0] wbits;

  // ==========================================================
  // line sources: pins low, the two internal sources on top
  assign line_lvl = {timer_wake_line, supply_monitor_line, pin_lines};

  // ==========================================================
  // bus front end
  extlc_wb_slave u_wb (
    .clk      (clk),
    .sys_rst  (sys_rst),
    .wb_cyc   (wb_cyc),
    .wb_stb   (wb_stb),
    .wb_we    (wb_we),
    .wb_adr   (wb_adr),
    .wb_sel   (wb_sel),
    .wb_dat_w (wb_dat_w),
    .wb_dat_r (wb_dat_r),
    .wb_ack   (wb_ack),
    .acc      (acc),
    .rdata    (rdata)
  );

  // ==========================================================
  // edge detection
  extlc_edge_det u_edge (
    .clk              (clk),
    .sys_rst          (sys_rst),
    .line_lvl         (line_lvl),
    .rise_trigger_sel (cfg.rise_sel),
    .fall_trigger_sel (cfg.fall_sel),
    .edge_hit         (edge_hit)
  );

  // ==========================================================
  // write decode
  // bits 31:20 are dropped on write, so they always read back as reset
  assign wmask = acc.mask[NUM_LINES-1:0];
  assign wbits = acc.dat[NUM_LINES-1:0];

  always_comb begin
    wr_irq_en = 1'b0;
    wr_evt_en = 1'b0;
    wr_rise   = 1'b0;
    wr_fall   = 1'b0;
    wr_soft   = 1'b0;
    wr_pend   = 1'b0;
    wr_sclr   = 1'b0;
    wr_sen    = 1'b0;
    if (acc.wr) begin
      if (acc.adr == OFS_IRQ_EN) begin
        wr_irq_en = 1'b1;
      end else if (acc.adr == OFS_EVT_EN) begin
        wr_evt_en = 1'b1;
      end else if (acc.adr == OFS_RISE_SEL) begin
        wr_rise = 1'b1;
      end else if (acc.adr == OFS_FALL_SEL) begin
        wr_fall = 1'b1;
      end else if (acc.adr == OFS_SOFT_TRG) begin
        wr_soft = 1'b1;
      end else if (acc.adr == OFS_PENDING) begin
        wr_pend = 1'b1;
      end else if (acc.adr == OFS_STAT_CLR) begin
        wr_sclr = 1'b1;
      end else if (acc.adr == OFS_STAT_EN) begin
        wr_sen = 1'b1;
      end
    end
  end

  // ==========================================================
  // read decode; unmapped and write-only offsets read zero
  always_comb begin
    rdata = WORD_ZERO;
    if (acc.adr == OFS_IRQ_EN) begin
      rdata[NUM_LINES-1:0] = irq_en_q;
    end else if (acc.adr == OFS_EVT_EN) begin
      rdata[NUM_LINES-1:0] = evt_en_q;
    end else if (acc.adr == OFS_RISE_SEL) begin
      rdata[NUM_LINES-1:0] = rise_sel_q;
    end else if (acc.adr == OFS_FALL_SEL) begin
      rdata[NUM_LINES-1:0] = fall_sel_q;
    end else if (acc.adr == OFS_SOFT_TRG) begin
      rdata[NUM_LINES-1:0] = soft_trigger_q;
    end else if (acc.adr == OFS_PENDING) begin
      rdata[NUM_LINES-1:0] = pending_q;
    end else if (acc.adr == OFS_STATUS) begin
      rdata[STAT_W-1:0] = status_q;
    end else if (acc.adr == OFS_STAT_EN) begin
      rdata[STAT_W-1:0] = stat_en_q;
    end
  end

  // ==========================================================
  // configuration registers, byte lanes honoured
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      irq_en_q <= LINES_RST;
    end else if (wr_irq_en) begin
      irq_en_q <= (irq_en_q & ~wmask) | (wbits & wmask);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_en_q <= LINES_RST;
    end else if (wr_evt_en) begin
      evt_en_q <= (evt_en_q & ~wmask) | (wbits & wmask);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      rise_sel_q <= LINES_RST;
    end else if (wr_rise) begin
      rise_sel_q <= (rise_sel_q & ~wmask) | (wbits & wmask);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      fall_sel_q <= LINES_RST;
    end else if (wr_fall) begin
      fall_sel_q <= (fall_sel_q & ~wmask) | (wbits & wmask);
    end
  end

  // regrouped flops for the detector and the request logic
  // no extra stage, so a new select or enable acts one cycle after its write
  always_comb begin
    cfg.irq_en   = irq_en_q;
    cfg.evt_en   = evt_en_q;
    cfg.rise_sel = rise_sel_q;
    cfg.fall_sel = fall_sel_q;
  end

  // ==========================================================
  // software trigger
  // only a 0 to 1 write fires; rewriting a one that is still set is quiet
  assign soft_set = {NUM_LINES{wr_soft}} & wmask & wbits & ~soft_trigger_q;
  assign pend_clr = {NUM_LINES{wr_pend}} & wmask & wbits;

  // a soft write replaces its enabled byte lanes; otherwise a pending clear drops its trigger bit
  always_comb begin
    soft_trigger_d = soft_trigger_q & ~pend_clr;
    if (wr_soft) begin
      soft_trigger_d = (soft_trigger_q & ~wmask) | (wbits & wmask);
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      soft_trigger_q <= LINES_RST;
    end else begin
      soft_trigger_q <= soft_trigger_d;
    end
  end

  // ==========================================================
  // pending flags
  // an edge on an event-only line (event on, irq off) leaves pending alone; a soft trigger still sets it
  assign pend_set = (edge_hit & (cfg.irq_en | ~cfg.evt_en))
                  | soft_set;

  // set wins over a clear in the same cycle
  assign pending_d = (pending_q & ~pend_clr) | pend_set;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      pending_q <= LINES_RST;
    end else begin
      pending_q <= pending_d;
    end
  end

  // ==========================================================
  // requests out
  assign line_irq_req = pending_q & cfg.irq_en;

  // one registered pulse per qualified edge or soft trigger
  assign evt_fire = (edge_hit | soft_set) & cfg.evt_en;

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      event_q <= LINES_RST;
    end else begin
      event_q <= evt_fire;
    end
  end

  assign line_event = event_q;

  // ==========================================================
  // controller status: sticky, write-one clear, set wins
  always_comb begin
    stat_hit              = STAT_RST;
    stat_hit[ST_PEND_SET] = |pend_set;
    stat_hit[ST_PEND_HIT] = |(pend_set & pending_q);
    stat_hit[ST_EVT_OUT]  = |evt_fire;
    status_d              = status_q;
    if (wr_sclr) begin
      status_d = status_q & ~(wbits[STAT_W-1:0] & wmask[STAT_W-1:0]);
    end
    status_d = status_d | stat_hit;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      status_q <= STAT_RST;
    end else begin
      status_q <= status_d;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      stat_en_q <= STAT_RST;
    end else if (wr_sen) begin
      stat_en_q <= (stat_en_q & ~wmask[STAT_W-1:0]) | (wbits[STAT_W-1:0] & wmask[STAT_W-1:0]);
    end
  end

  assign ctrl_irq = |(status_q & stat_en_q);

endmodule : extlc_top

// ===== test/extlc_cpu_model.sv
// far-side consumer that counts event pulses from the line controller
`timescale 1ns/10ps
module extlc_cpu_model
  import extlc_pkg::*;
(
  input  wire logic                 clk,
  input  wire logic                 sys_rst,
  input  wire logic [NUM_LINES-1:0] line_event,
  output logic      [15:0]          evt_cnt_q
);
  // ========
  // counter
  // a stretched pulse counts once per cycle it is high, so pulse width shows up in the total
  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      evt_cnt_q <= 16'h0000;
    end else begin
      evt_cnt_q <= evt_cnt_q + 16'($countones(line_event));
    end
  end
endmodule : extlc_cpu_model

// ===== test/extlc_assertions.sv
// port-level checks of the line controller
`timescale 1ns/10ps
module extlc_chk
  import extlc_pkg::*;
(
  input wire logic                 clk,
  input wire logic                 sys_rst,
  input wire logic                 wb_cyc,
  input wire logic                 wb_stb,
  input wire logic                 wb_we,
  input wire logic [ADR_W-1:0]     wb_adr,
  input wire logic [3:0]           wb_sel,
  input wire logic [31:0]          wb_dat_w,
  input wire logic [31:0]          wb_dat_r,
  input wire logic                 wb_ack,
  input wire logic [NUM_PINS-1:0]  pin_lines,
  input wire logic                 supply_monitor_line,
  input wire logic                 timer_wake_line,
  input wire logic [NUM_LINES-1:0] line_irq_req,
  input wire logic [NUM_LINES-1:0] line_event,
  input wire logic                 ctrl_irq
);
  // ========
  // helpers
  wire logic [NUM_LINES-1:0] lines = {timer_wake_line, supply_monitor_line, pin_lines};
  wire logic                 req   = wb_cyc && wb_stb && !wb_ack;
  wire logic                 wr    = req && wb_we;
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  // ========
  // properties
  a_ack_answer: assert property (req |=> wb_ack) else $error("ack missing");
  a_ack_pulse: assert property (wb_ack |=> !wb_ack) else $error("ack too long");
  a_ack_cause: assert property ($rose(wb_ack) |-> $past(req)) else $error("ack without request");
  a_rd_upper: assert property (wb_ack && !$past(wb_we) |-> wb_dat_r[31:20] == 12'h000)
    else $error("upper read bits set");
  a_reset_quiet: assert property ($past(sys_rst) |-> line_irq_req == 20'h00000 && !ctrl_irq)
    else $error("request out of reset");
  a_event_cause: assert property ($stable(lines) && !wr |=> line_event == 20'h00000)
    else $error("event without edge");
  a_irq_rise: assert property ($stable(lines) && !wr |=> (line_irq_req & ~$past(line_irq_req)) == 20'h00000)
    else $error("request without cause");
  a_irq_hold: assert property (!wr |=> (~line_irq_req & $past(line_irq_req)) == 20'h00000)
    else $error("request dropped");
  c_write: cover property (wr);
  c_event: cover property (line_event != 20'h00000);
  c_irq: cover property ($rose(ctrl_irq));
endmodule : extlc_chk

// ===== test/tb.sv
// self-checking bench of the external line controller
`timescale 1ns/10ps
module tb;
  import extlc_pkg::*;
  logic                 clk, sys_rst, wb_cyc, wb_stb, wb_we, wb_ack, ctrl_irq, e;
  logic [ADR_W-1:0]     wb_adr;
  logic [3:0]           wb_sel;
  logic [31:0]          wb_dat_w, wb_dat_r, rd, base;
  logic [NUM_LINES-1:0] lines, line_irq_req, line_event;
  logic [15:0]          evt_cnt;
  int                   err_count, samples_checked, cycles, seed, l;
  extlc_top dut (.clk(clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb), .wb_we(wb_we),
    .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r), .wb_ack(wb_ack),
    .pin_lines(lines[17:0]), .supply_monitor_line(lines[18]), .timer_wake_line(lines[19]),
    .line_irq_req(line_irq_req), .line_event(line_event), .ctrl_irq(ctrl_irq));
  extlc_cpu_model u_cpu (.clk(clk), .sys_rst(sys_rst), .line_event(line_event), .evt_cnt_q(evt_cnt));
  // ========
  // helpers
  function automatic logic [31:0] bit_of(int n, logic on);
    return on ? 32'h00000001 << n : 32'h00000000;
  endfunction : bit_of
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", samples_checked, err_count);
    if (err_count == 0 && samples_checked > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : give_verdict
  // request held to the rising edge that sees ack; data taken and request released there
  // the trailing half cycle lets callers compare settled outputs
  task automatic wbx(input logic w, input logic [ADR_W-1:0] a, input logic [31:0] d);
    @(posedge clk);
    wb_cyc   <= 1'b1;
    wb_stb   <= 1'b1;
    wb_we    <= w;
    wb_adr   <= a;
    wb_sel   <= 4'hF;
    wb_dat_w <= d;
    do @(posedge clk); while (wb_ack !== 1'b1);
    rd = wb_dat_r;
    wb_cyc <= 1'b0;
    wb_stb <= 1'b0;
    @(negedge clk);
  endtask : wbx
  task automatic drive(input logic v);
    @(posedge clk);
    lines[l] <= v;
    repeat (2) @(posedge clk);
    @(negedge clk);
  endtask : drive
  // ========
  // clock and watchdog
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 5000) begin
      err_count++;
      give_verdict();
    end
  end
  // ========
  // sequence
  initial begin
    seed = 58872;
    sys_rst = 1'b1;
    {wb_cyc, wb_stb, wb_we} = 3'h0;
    wb_adr = 8'h00;
    wb_sel = 4'hF;
    wb_dat_w = 32'h00000000;
    lines = 20'h00000;
    repeat (6) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 10; a++) begin
      wbx(1'b0, ADR_W'(a * 4), 32'h00000000);
      chk(rd, 32'h00000000);
    end
    wbx(1'b1, 8'h24, 32'h000FFFFF);
    wbx(1'b0, 8'h24, 32'h00000000);
    chk(rd, 32'h00000000);
    for (int a = 0; a < 5; a++) begin
      base = $random(seed) & 32'h000FFFFF;
      wbx(1'b1, ADR_W'(a * 4), base);
      wbx(1'b0, ADR_W'(a * 4), 32'h00000000);
      chk(rd, base);
      wbx(1'b1, ADR_W'(a * 4), 32'h00000000);
    end
    wbx(1'b1, OFS_PENDING, 32'h000FFFFF);
    $display("register test done");
    wbx(1'b1, OFS_IRQ_EN, 32'h000FFFFF);
    for (int m = 0; m < 4; m++) begin
      l = {$random(seed)} % NUM_LINES;
      wbx(1'b1, OFS_RISE_SEL, bit_of(l, m[0]));
      wbx(1'b1, OFS_FALL_SEL, bit_of(l, m[1]));
      for (int v = 1; v >= 0; v--) begin
        e = v ? m[0] : m[1];
        drive(v[0]);
        chk({31'h0, line_irq_req[l]}, bit_of(0, e));
        wbx(1'b0, OFS_PENDING, 32'h00000000);
        chk(rd, bit_of(l, e));
        wbx(1'b1, OFS_PENDING, bit_of(l, 1'b1));
        wbx(1'b0, OFS_PENDING, 32'h00000000);
        chk(rd, 32'h00000000);
      end
      $display("edge mode %0d done", m);
    end
    chk({16'h0, evt_cnt}, 32'h00000000);
    wbx(1'b1, OFS_IRQ_EN, 32'h00000000);
    wbx(1'b1, OFS_EVT_EN, bit_of(l, 1'b1));
    wbx(1'b1, OFS_RISE_SEL, bit_of(l, 1'b1));
    wbx(1'b1, OFS_FALL_SEL, 32'h00000000);
    drive(1'b1);
    drive(1'b0);
    chk({16'h0, evt_cnt}, 32'h00000001);
    wbx(1'b0, OFS_PENDING, 32'h00000000);
    chk(rd, 32'h00000000);
    $display("event test done");
    wbx(1'b1, OFS_STAT_CLR, 32'h00000007);
    wbx(1'b1, OFS_STAT_EN, 32'h00000001);
    chk({31'h0, ctrl_irq}, 32'h00000000);
    wbx(1'b1, OFS_SOFT_TRG, bit_of(l, 1'b1));
    chk({31'h0, line_irq_req[l]}, 32'h00000000);
    chk({16'h0, evt_cnt}, 32'h00000002);
    wbx(1'b0, OFS_STATUS, 32'h00000000);
    chk(rd, bit_of(ST_PEND_SET, 1'b1) | bit_of(ST_EVT_OUT, 1'b1));
    chk({31'h0, ctrl_irq}, 32'h00000001);
    wbx(1'b0, OFS_PENDING, 32'h00000000);
    chk(rd, bit_of(l, 1'b1));
    wbx(1'b1, OFS_IRQ_EN, bit_of(l, 1'b1));
    chk({12'h0, line_irq_req}, bit_of(l, 1'b1));
    wbx(1'b1, OFS_STAT_EN, 32'h00000000);
    chk({31'h0, ctrl_irq}, 32'h00000000);
    wbx(1'b1, OFS_STAT_EN, 32'h00000001);
    chk({31'h0, ctrl_irq}, 32'h00000001);
    wbx(1'b1, OFS_STAT_CLR, 32'h00000001);
    chk({31'h0, ctrl_irq}, 32'h00000000);
    wbx(1'b1, OFS_PENDING, 32'h00000000);
    wbx(1'b0, OFS_PENDING, 32'h00000000);
    chk(rd, bit_of(l, 1'b1));
    wbx(1'b1, OFS_PENDING, bit_of(l, 1'b1));
    wbx(1'b0, OFS_SOFT_TRG, 32'h00000000);
    chk(rd, 32'h00000000);
    chk({12'h0, line_irq_req}, 32'h00000000);
    $display("soft trigger test done");
    give_verdict();
  end
endmodule : tb
bind extlc_top extlc_chk u_chk (.clk(clk), .sys_rst(sys_rst), .wb_cyc(wb_cyc), .wb_stb(wb_stb),
  .wb_we(wb_we), .wb_adr(wb_adr), .wb_sel(wb_sel), .wb_dat_w(wb_dat_w), .wb_dat_r(wb_dat_r),
  .wb_ack(wb_ack), .pin_lines(pin_lines), .supply_monitor_line(supply_monitor_line),
  .timer_wake_line(timer_wake_line), .line_irq_req(line_irq_req), .line_event(line_event),
  .ctrl_irq(ctrl_irq));
